// ==== unvm_pkg.sv ====
/*
 * Package for the user nonvolatile store byte-read port: geometry, field
 * positions, reset values and the programming-port command encodings.
 * Assumes nothing of its surroundings; imported by both design files.
 */
`default_nettype none

package unvm_pkg;

    localparam int UNVM_BANKS = 8;
    localparam int UNVM_BANK_BITS = 128;
    localparam int UNVM_BYTE_W = 8;
    localparam int UNVM_BYTES_PER_BANK = UNVM_BANK_BITS / UNVM_BYTE_W;
    localparam int UNVM_TOTAL_BITS = UNVM_BANKS * UNVM_BANK_BITS;
    localparam int UNVM_DEPTH = UNVM_TOTAL_BITS / UNVM_BYTE_W;
    localparam int UNVM_ADDR_W = 7;
    localparam int UNVM_BANK_W = 3;
    localparam int UNVM_BYTE_SEL_W = 4;
    localparam int UNVM_BANK_LSB = 4;
    localparam int UNVM_BYTE_LSB = 0;
    localparam int UNVM_AES_KEY_W = 8;

    // Value of an erased byte, and of output data after reset.
    localparam logic [7:0] UNVM_ERASED_BYTE = 8'hFF;
    localparam logic [7:0] UNVM_DATA_RST = 8'h00;
    localparam logic [7:0] UNVM_AES_KEY_RST = 8'h00;
    // Cycles an erase walks through, one byte per cycle.
    localparam int UNVM_ERASE_CYCLES = UNVM_DEPTH;

    typedef enum logic [1:0] {
        UNVM_CMD_NOP = 2'h0,
        UNVM_CMD_WRITE = 2'h1,
        UNVM_CMD_ERASE = 2'h2,
        UNVM_CMD_READ = 2'h3
    } unvm_cmd_t;

    typedef enum logic [1:0] {
        UNVM_ST_IDLE = 2'b00,
        UNVM_ST_ERASE = 2'b01,
        UNVM_ST_DONE = 2'b11
    } unvm_state_t;

    // Fabric read request.
    typedef struct packed {
        logic valid;
        logic [UNVM_ADDR_W-1:0] addr;
    } unvm_rd_req_t;

    // Programming-port request.
    typedef struct packed {
        unvm_cmd_t cmd;
        logic encrypted;
        logic [UNVM_ADDR_W-1:0] addr;
        logic [7:0] data;
    } unvm_prog_req_t;

    function automatic logic [UNVM_BANK_W-1:0] unvm_bank_of(input logic [UNVM_ADDR_W-1:0] a);
        return a[UNVM_BANK_LSB +: UNVM_BANK_W];
    endfunction

    function automatic logic [UNVM_BYTE_SEL_W-1:0] unvm_byte_of(input logic [UNVM_ADDR_W-1:0] a);
        return a[UNVM_BYTE_LSB +: UNVM_BYTE_SEL_W];
    endfunction

endpackage

`default_nettype wire

// ==== unvm_store_mem.sv ====
/*
 * Byte memory holding the user nonvolatile store contents, one write port
 * and two registered read ports.
 * Assumes a single clock; the write port is reached only from the
 * programming side of the parent.
 */
`timescale 1ns/10ps
`default_nettype none

module unvm_store_mem
    import unvm_pkg::*;
#(
    parameter int DEPTH = UNVM_DEPTH,
    parameter int AW = UNVM_ADDR_W,
    parameter int DW = UNVM_BYTE_W
) (
    // Clock.
    input wire logic clk,
    // Write port.
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    // Read port A.
    input wire logic [AW-1:0] rdAddrA,
    output logic [DW-1:0] rdDataA,
    // Read port B.
    input wire logic [AW-1:0] rdAddrB,
    output logic [DW-1:0] rdDataB
);

    logic [DW-1:0] mem [DEPTH];

    // The array has no reset: its contents persist like the stored cells.
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        rdDataA <= mem[rdAddrA];
    end

    always_ff @(posedge clk) begin
        rdDataB <= mem[rdAddrB];
    end

endmodule

`default_nettype wire

// ==== unvm_read_port.sv ====
/*
 * User nonvolatile store with a byte-wide synchronous fabric read port and
 * a programming-port access path (erase, write, readback).
 * Assumes the fabric reader and the programming controller both run on clk;
 * the programming side is the boundary-scan controller's decoded output.
 */
`timescale 1ns/10ps
`default_nettype none

module unvm_read_port
    import unvm_pkg::*;
#(
    parameter int ADDR_W = UNVM_ADDR_W,
    parameter logic [7:0] AES_KEY = UNVM_AES_KEY_RST
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Fabric read port.
    input wire unvm_rd_req_t rdReq,
    output logic [7:0] rdData,
    output logic rdValid,
    // Programming port.
    input wire unvm_prog_req_t progReq,
    output logic progBusy,
    output logic progAck,
    output logic [7:0] progRdData,
    output logic progRdValid
);

    unvm_state_t state_r;
    unvm_state_t state_nxt;
    logic [ADDR_W-1:0] eraseAddr_r;
    logic [ADDR_W-1:0] eraseAddr_nxt;
    logic eraseLast;
    logic [ADDR_W-1:0] fabAddr;
    logic [ADDR_W-1:0] memWrAddr;
    logic [7:0] memWrData;
    logic memWrEn;
    logic [7:0] fabByte;
    logic [7:0] progByte;
    logic rdPend_r;
    logic progRdPend_r;

    // Programming commands taken this cycle.
    logic wrTake;
    logic eraseTake;
    logic readTake;

    // Output registers.
    logic [7:0] rdData_r;
    logic rdValid_r;
    logic progAck_r;
    logic progAck_nxt;
    logic [7:0] progRdData_r;
    logic progRdValid_r;

    // Bank and byte fields rebuilt into the linear byte index.
    assign fabAddr = {unvm_bank_of(rdReq.addr), unvm_byte_of(rdReq.addr)};

    // A command is taken only while the store is idle. Anything sent during an erase is dropped
    // without notice, so the programming side has to watch progBusy.
    function automatic logic unvm_cmd_taken(input unvm_state_t st, input unvm_cmd_t cmd, input unvm_cmd_t want);
        return (st == UNVM_ST_IDLE) && (cmd == want);
    endfunction

    assign wrTake = unvm_cmd_taken(state_r, progReq.cmd, UNVM_CMD_WRITE);
    assign eraseTake = unvm_cmd_taken(state_r, progReq.cmd, UNVM_CMD_ERASE);
    assign readTake = unvm_cmd_taken(state_r, progReq.cmd, UNVM_CMD_READ);

    // Only the programming side drives the write port; fabric has no path in.
    always_comb begin
        memWrEn = 1'h0;
        memWrAddr = progReq.addr;
        // The key stands in for the decryption engine; a plain XOR keeps the write path one cycle deep.
        memWrData = progReq.encrypted ? (progReq.data ^ AES_KEY) : progReq.data;
        if (state_r == UNVM_ST_ERASE) begin
            memWrEn = 1'h1;
            memWrAddr = eraseAddr_r;
            memWrData = UNVM_ERASED_BYTE;
        end else if (wrTake) begin
            memWrEn = 1'h1;
        end
    end

    // The second read port serves readback, so a programming read never stalls a fabric read.
    unvm_store_mem #(
        .DEPTH(UNVM_BANKS * UNVM_BYTES_PER_BANK),
        .AW(ADDR_W),
        .DW(UNVM_BYTE_W)
    ) u_mem (
        .clk(clk),
        .wrEn(memWrEn),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .rdAddrA(fabAddr),
        .rdDataA(fabByte),
        .rdAddrB(progReq.addr),
        .rdDataB(progByte)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            UNVM_ST_IDLE: begin
                if (eraseTake) begin
                    state_nxt = UNVM_ST_ERASE;
                end
            end
            UNVM_ST_ERASE: begin
                if (eraseLast) begin
                    state_nxt = UNVM_ST_DONE;
                end
            end
            UNVM_ST_DONE: begin
                state_nxt = UNVM_ST_IDLE;
            end
            default: begin
                state_nxt = UNVM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= UNVM_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // The erase walks every byte once, one per cycle, and ends at the last index.
    assign eraseLast = (eraseAddr_r == ADDR_W'(UNVM_ERASE_CYCLES - 1));
    assign eraseAddr_nxt = (state_r == UNVM_ST_ERASE) ? eraseAddr_r + ADDR_W'(1) : '0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eraseAddr_r <= '0;
        end else begin
            eraseAddr_r <= eraseAddr_nxt;
        end
    end

    // Fabric reads: address taken at one edge, byte stands from the next.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdPend_r <= 1'b0;
        end else begin
            rdPend_r <= rdReq.valid;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_r <= UNVM_DATA_RST;
        end else if (rdPend_r) begin
            // The byte holds between reads, so a slow reader may still pick it up late.
            rdData_r <= fabByte;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdValid_r <= 1'h0;
        end else begin
            rdValid_r <= rdPend_r;
        end
    end

    // Programming-port readback runs beside fabric reads.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            progRdPend_r <= 1'b0;
        end else begin
            progRdPend_r <= readTake;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            progRdData_r <= UNVM_DATA_RST;
        end else if (progRdPend_r) begin
            progRdData_r <= progByte;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            progRdValid_r <= 1'h0;
        end else begin
            progRdValid_r <= progRdPend_r;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            progAck_r <= 1'h0;
        end else begin
            progAck_r <= progAck_nxt;
        end
    end

    // A write is acknowledged on the next edge; an erase only once its last byte has landed.
    assign progAck_nxt = wrTake || (state_r == UNVM_ST_DONE);

    // Every data and pulse output leaves straight from its own flip-flop.
    assign rdData = rdData_r;
    assign rdValid = rdValid_r;
    assign progAck = progAck_r;
    assign progRdData = progRdData_r;
    assign progRdValid = progRdValid_r;
    assign progBusy = (state_r != UNVM_ST_IDLE);

endmodule

`default_nettype wire

// ==== unvm_read_port_checker.sv ====
/* Timing assertions on the user nonvolatile store read port.
   Assumes it is bound to unvm_read_port and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module unvm_read_port_checker
    import unvm_pkg::*;
(
    // Watched ports.
    input wire logic clk,
    input wire logic sys_rst,
    input wire unvm_rd_req_t rdReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire unvm_prog_req_t progReq,
    input wire logic progBusy,
    input wire logic progAck,
    input wire logic progRdValid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // A command counts only when the port is idle.
    logic [1:0] cmd;
    assign cmd = progBusy ? UNVM_CMD_NOP : progReq.cmd;
    property p_rlat; rdReq.valid |-> ##2 rdValid; endproperty
    a_rlat: assert property (p_rlat) else $error("read late");
    property p_rsrc; rdValid |-> $past(rdReq.valid, 2); endproperty
    a_rsrc: assert property (p_rsrc) else $error("stray read");
    property p_rhold; !rdValid |-> $stable(rdData); endproperty
    a_rhold: assert property (p_rhold) else $error("data moved");
    property p_wack; cmd == UNVM_CMD_WRITE |=> progAck; endproperty
    a_wack: assert property (p_wack) else $error("no write ack");
    property p_ebusy; cmd == UNVM_CMD_ERASE |=> progBusy [*8]; endproperty
    a_ebusy: assert property (p_ebusy) else $error("erase not busy");
    property p_eack; cmd == UNVM_CMD_ERASE |-> ##130 progAck; endproperty
    a_eack: assert property (p_eack) else $error("erase ack late");
    property p_eend; $fell(progBusy) |-> progAck; endproperty
    a_eend: assert property (p_eend) else $error("busy end no ack");
    property p_prd; cmd == UNVM_CMD_READ |-> ##2 progRdValid; endproperty
    a_prd: assert property (p_prd) else $error("readback late");
    c_read: cover property (rdValid);
    c_erase: cover property ($fell(progBusy));
    c_back: cover property (progRdValid);
endmodule
bind unvm_read_port unvm_read_port_checker chk (.clk, .sys_rst, .rdReq, .rdData, .rdValid, .progReq,
    .progBusy, .progAck, .progRdValid);
`default_nettype wire

// ==== unvm_fabric_reader.sv ====
/* Fabric logic that reads stored bytes one at a time.
   Assumes the read port answers two edges after a request. */
`timescale 1ns/10ps
`default_nettype none
module unvm_fabric_reader
    import unvm_pkg::*;
(
    // Clock and read interface.
    input wire logic clk,
    output var unvm_rd_req_t rdReq,
    input wire logic [7:0] rdData,
    input wire logic rdValid
);
    initial rdReq = '0;
    // The address is scrambled once released so a stale value never passes.
    task automatic read_byte(input logic [6:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        rdReq <= {1'b1, a};
        @(negedge clk);
        rdReq <= {1'b0, ~a};
        while (rdValid !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        d = rdValid === 1'b1 ? rdData : 8'hXX;
    endtask
endmodule
`default_nettype wire

// ==== unvm_read_port_bench.sv ====
/* Self-checking bench for the user nonvolatile store read port.
   Assumes the fabric reader model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module unvm_read_port_bench
    import unvm_pkg::*;
;
    localparam logic [7:0] KEY = 8'h3C;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    unvm_rd_req_t rdReq;
    unvm_prog_req_t progReq = '0;
    logic [7:0] rdData, progRdData, d;
    logic rdValid, progBusy, progAck, progRdValid;
    int errorCnt = 0;
    int numChecks = 0;
    int cycles = 0;
    initial forever #4 clk = ~clk;
    unvm_read_port #(.AES_KEY(KEY)) dut (.clk, .sys_rst, .rdReq, .rdData, .rdValid, .progReq, .progBusy,
        .progAck, .progRdData, .progRdValid);
    unvm_fabric_reader reader (.clk, .rdReq, .rdData, .rdValid);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", errorCnt, numChecks);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic prog(input unvm_cmd_t c, input logic [6:0] a, input logic [7:0] v, input logic e);
        @(negedge clk);
        progReq <= '{c, e, a, v};
        @(negedge clk);
        progReq <= '{UNVM_CMD_NOP, ~e, ~a, ~v};
    endtask
    // A write sent while erasing must be ignored.
    task automatic t_erase();
        prog(UNVM_CMD_ERASE, 7'h00, 8'h00, 1'b0);
        check({7'h00, progBusy}, 8'h01);
        prog(UNVM_CMD_WRITE, 7'h05, 8'h11, 1'b0);
        while (progBusy !== 1'b0) @(negedge clk);
        check({7'h00, progAck}, 8'h01);
        reader.read_byte(7'h05, d);
        check(d, UNVM_ERASED_BYTE);
        reader.read_byte(7'h7F, d);
        check(d, UNVM_ERASED_BYTE);
    endtask
    // First and last byte of every bank.
    task automatic t_banks();
        for (int i = 0; i < 16; i++) begin
            prog(UNVM_CMD_WRITE, {i[3:1], {4{i[0]}}}, {i[3:0], ~i[3:0]}, 1'b0);
        end
        for (int i = 0; i < 16; i++) begin
            reader.read_byte({i[3:1], {4{i[0]}}}, d);
            check(d, {i[3:0], ~i[3:0]});
        end
    endtask
    task automatic t_back();
        prog(UNVM_CMD_WRITE, 7'h40, 8'h96, 1'b1);
        check({7'h00, progAck}, 8'h01);
        prog(UNVM_CMD_READ, 7'h40, 8'h00, 1'b0);
        @(negedge clk);
        check({7'h00, progRdValid}, 8'h01);
        check(progRdData, 8'h96 ^ KEY);
        reader.read_byte(7'h40, d);
        check(d, 8'h96 ^ KEY);
    endtask
    // A mid-run reset clears the outputs and keeps the stored bytes.
    task automatic t_reset();
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        check(rdData, UNVM_DATA_RST);
        check(progRdData, UNVM_DATA_RST);
        check({4'h0, rdValid, progRdValid, progBusy, progAck}, 8'h00);
        reader.read_byte(7'h40, d);
        check(d, 8'h96 ^ KEY);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        t_erase();
        t_banks();
        t_back();
        t_reset();
        report_and_stop();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errorCnt++;
            report_and_stop();
        end
    end
endmodule
`default_nettype wire
